// File: rtl/arc_pkg.sv
package arc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] ADDR_EXC     = 8'hD5;
    localparam logic [7:0] ADDR_GAIN_LO = 8'hEC;
    localparam logic [7:0] ADDR_GAIN_HI = 8'hED;
    localparam logic [7:0] ADDR_DECIM   = 8'hD6;

    localparam logic [7:0]  EXC_RESET   = 8'h00;
    localparam logic [7:0]  EXC_MASK    = 8'h7F;
    localparam logic [7:0]  DECIM_RESET = 8'h45;
    localparam logic [7:0]  DECIM_CAL   = 8'hFF;
    localparam logic [7:0]  DECIM_MIN   = 8'h0D;
    localparam logic [15:0] GAIN_RESET  = 16'h0000;
    localparam logic [7:0]  RDATA_NONE  = 8'h00;
    localparam logic [2:0]  MODE_IDLE   = 3'h0;

    // current control fields
    localparam int BIT_SRC1_EN   = 0;
    localparam int BIT_SRC2_EN   = 1;
    localparam int BIT_SRC1_PIN  = 2;
    localparam int BIT_SRC2_PIN  = 3;
    localparam int BIT_PRIM_CORR = 4;
    localparam int BIT_AUX_CORR  = 5;
    localparam int BIT_BURNOUT   = 6;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int REF_CLK_HZ  = 125000000;
    localparam int MOD_CLK_HZ  = 32768;
    localparam int MOD_DIV_CYC = REF_CLK_HZ / MOD_CLK_HZ;
    localparam logic [12:0] FILTER_MUL     = 13'h0018;
    localparam logic [1:0]  SETTLE_PERIODS = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } arc_sfr_req_t;

    typedef struct packed {
        logic        busy;
        logic        gain_done;
        logic [15:0] gain;
    } arc_cal_t;

    typedef struct packed {
        logic burnout;
        logic aux_corr;
        logic prim_corr;
        logic src1_first;
        logic src1_second;
        logic src2_first;
        logic src2_second;
    } arc_exc_t;

    typedef enum logic [2:0] {
        T_IDLE   = 3'b001,
        T_SETTLE = 3'b010,
        T_RUN    = 3'b100
    } arc_tstate_t;

endpackage

// File: rtl/arc_gain_store.sv
`timescale 1ns/1ps
`default_nettype none
module arc_gain_store (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // load sources
    input  wire logic        load_factory,
    input  wire logic [15:0] factory_gain,
    input  wire logic        cal_load,
    input  wire logic [15:0] cal_gain,
    input  wire logic        wr_lo,
    input  wire logic        wr_hi,
    input  wire logic [7:0]  wdata,
    input  wire logic        mode_idle,
    // stored value
    output logic [15:0]      gain
);

    typedef struct packed {
        logic [15:0] gain;
    } arc_gs_st_t;

    arc_gs_st_t st_ff;
    arc_gs_st_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_st = st_ff;
        if (load_factory) begin
            nxt_st.gain = factory_gain;
        end else if (cal_load) begin
            nxt_st.gain = cal_gain;
        end else if (mode_idle) begin
            if (wr_lo) begin
                nxt_st.gain[7:0] = wdata;
            end
            if (wr_hi) begin
                nxt_st.gain[15:8] = wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.gain <= arc_pkg::GAIN_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign gain = st_ff.gain;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_gain_cal_load: assert property (
        cal_load && !load_factory |=> gain == $past(cal_gain))
        else $error("gain not replaced by calibration");
    a_gain_wr_lock: assert property (
        (wr_lo || wr_hi) && !mode_idle && !cal_load && !load_factory
        |=> $stable(gain))
        else $error("gain changed while mode not idle");
    a_gain_wr_lo: assert property (
        wr_lo && !wr_hi && mode_idle && !cal_load && !load_factory
        |=> gain[7:0] == $past(wdata) && $stable(gain[15:8]))
        else $error("low gain byte write lost");

endmodule // arc_gain_store
`default_nettype wire

// File: rtl/arc_rate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module arc_rate_timer #(
    parameter int MOD_DIV = arc_pkg::MOD_DIV_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic [7:0] factor,
    input  wire logic       start,
    input  wire logic       continuous,
    // status
    output logic            busy,
    output logic            result
);

    localparam logic [11:0] DIV_LAST = 12'(MOD_DIV - 1);

    typedef struct packed {
        arc_pkg::arc_tstate_t state;
        logic [11:0]          div_cnt;
        logic [12:0]          per_cnt;
        logic [1:0]           nper;
        logic                 result;
    } arc_rt_st_t;

    arc_rt_st_t  st_ff;
    arc_rt_st_t  nxt_st;
    logic        tick;
    logic        per_end;
    logic [12:0] per_len;

    ////////////////////////////////////////////////////////////////////////
    // modulator tick and output period
    assign tick    = st_ff.div_cnt == DIV_LAST;
    assign per_len = 13'(factor) * arc_pkg::FILTER_MUL;
    assign per_end = tick && (st_ff.per_cnt == per_len - 13'h0001);

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.result  = 1'b0;
        nxt_st.div_cnt = tick ? 12'h000 : st_ff.div_cnt + 12'h001;
        if (tick) begin
            nxt_st.per_cnt = per_end ? 13'h0000 : st_ff.per_cnt + 13'h0001;
        end
        unique case (st_ff.state)
            arc_pkg::T_IDLE: begin
                nxt_st.per_cnt = 13'h0000;
                nxt_st.nper    = 2'h0;
                if (start) begin
                    nxt_st.state = arc_pkg::T_SETTLE;
                end
            end
            arc_pkg::T_SETTLE: begin
                if (per_end) begin
                    if (st_ff.nper == arc_pkg::SETTLE_PERIODS - 2'h1) begin
                        nxt_st.result = 1'b1;
                        nxt_st.nper   = 2'h0;
                        nxt_st.state  = continuous ? arc_pkg::T_RUN
                                                   : arc_pkg::T_IDLE;
                    end else begin
                        nxt_st.nper = st_ff.nper + 2'h1;
                    end
                end
            end
            arc_pkg::T_RUN: begin
                if (!continuous) begin
                    nxt_st.state = arc_pkg::T_IDLE;
                end else if (per_end) begin
                    nxt_st.result = 1'b1;
                end
            end
            default: begin
                nxt_st.state = arc_pkg::T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.state   <= arc_pkg::T_IDLE;
            st_ff.div_cnt <= 12'h000;
            st_ff.per_cnt <= 13'h0000;
            st_ff.nper    <= 2'h0;
            st_ff.result  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy   = st_ff.state != arc_pkg::T_IDLE;
    assign result = st_ff.result;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_first_period;
        st_ff.state == arc_pkg::T_SETTLE && per_end && st_ff.nper == 2'h0;
    endsequence
    sequence s_second_period;
        st_ff.state == arc_pkg::T_SETTLE && per_end && st_ff.nper == 2'h1;
    endsequence

    a_settle_no_early: assert property (
        s_first_period |=> !result && st_ff.state == arc_pkg::T_SETTLE)
        else $error("result after one period");
    a_settle_second: assert property (
        s_second_period |=> result)
        else $error("no result after two periods");
    a_idle_quiet: assert property (
        st_ff.state == arc_pkg::T_IDLE && start |=> !result [*2])
        else $error("result without settling");
    a_period_len: assert property (
        tick && st_ff.state != arc_pkg::T_IDLE |->
        st_ff.per_cnt < 13'(factor) * arc_pkg::FILTER_MUL)
        else $error("period count beyond 24 times factor");

endmodule // arc_rate_timer
`default_nettype wire

// File: rtl/arc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl #(
    parameter int          MOD_DIV    = arc_pkg::MOD_DIV_CYC,
    parameter logic [7:0]  DECIM_ADDR = arc_pkg::ADDR_DECIM
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // special function register access
    input  wire arc_pkg::arc_sfr_req_t sfr_req,
    output logic [7:0]             sfr_rdata,
    // converter state
    input  wire logic [2:0]        converter_mode_field,
    input  wire logic              primary_active,
    input  wire logic              aux_active,
    input  wire logic              conv_start,
    input  wire logic              conv_continuous,
    // calibration engine
    input  wire arc_pkg::arc_cal_t cal,
    input  wire logic [15:0]       factory_gain,
    // filter and datapath
    output logic [7:0]             decimation_factor_eff,
    output logic [15:0]            aux_gain_coef,
    output logic                   conv_busy,
    output logic                   conv_result,
    // current sources
    output arc_pkg::arc_exc_t      exc
);

    typedef struct packed {
        logic [7:0] decim;
        logic [7:0] exc;
        logic [7:0] rdata;
        logic       fact_done;
    } arc_top_st_t;

    arc_top_st_t st_ff;
    arc_top_st_t nxt_st;
    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic        wr_exc;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_decim;
    logic        conv_any;
    logic        mode_idle;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = a == r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign wr_exc    = sfr_req.wr && hit(sfr_req.addr, arc_pkg::ADDR_EXC);
    assign wr_lo     = sfr_req.wr && hit(sfr_req.addr, arc_pkg::ADDR_GAIN_LO);
    assign wr_hi     = sfr_req.wr && hit(sfr_req.addr, arc_pkg::ADDR_GAIN_HI);
    assign wr_decim  = sfr_req.wr && hit(sfr_req.addr, DECIM_ADDR);
    assign conv_any  = primary_active || aux_active || conv_busy;
    assign mode_idle = converter_mode_field == arc_pkg::MODE_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.fact_done = 1'b1;
        if (wr_decim && !conv_any) begin
            nxt_st.decim = sfr_req.wdata;
        end
        if (wr_exc) begin
            nxt_st.exc = sfr_req.wdata & arc_pkg::EXC_MASK;
        end
        if (sfr_req.rd) begin
            if (hit(sfr_req.addr, arc_pkg::ADDR_EXC)) begin
                nxt_st.rdata = st_ff.exc;
            end else if (hit(sfr_req.addr, arc_pkg::ADDR_GAIN_LO)) begin
                nxt_st.rdata = aux_gain_coef[7:0];
            end else if (hit(sfr_req.addr, arc_pkg::ADDR_GAIN_HI)) begin
                nxt_st.rdata = aux_gain_coef[15:8];
            end else if (hit(sfr_req.addr, DECIM_ADDR)) begin
                nxt_st.rdata = st_ff.decim;
            end else begin
                nxt_st.rdata = arc_pkg::RDATA_NONE;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.decim     <= arc_pkg::DECIM_RESET;
            st_ff.exc       <= arc_pkg::EXC_RESET;
            st_ff.rdata     <= arc_pkg::RDATA_NONE;
            st_ff.fact_done <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sfr_rdata = st_ff.rdata;

    ////////////////////////////////////////////////////////////////////////
    // gain coefficient and rate
    arc_gain_store u_gain (
        .clk          (ref_clk),
        .rst_n        (rst_n),
        .load_factory (!st_ff.fact_done),
        .factory_gain (factory_gain),
        .cal_load     (cal.gain_done),
        .cal_gain     (cal.gain),
        .wr_lo        (wr_lo),
        .wr_hi        (wr_hi),
        .wdata        (sfr_req.wdata),
        .mode_idle    (mode_idle),
        .gain         (aux_gain_coef)
    );

    // calibration runs at the slowest rate, software value untouched
    assign decimation_factor_eff = cal.busy ? arc_pkg::DECIM_CAL
                                            : st_ff.decim;

    arc_rate_timer #(
        .MOD_DIV (MOD_DIV)
    ) u_timer (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .factor     (decimation_factor_eff),
        .start      (conv_start),
        .continuous (conv_continuous),
        .busy       (conv_busy),
        .result     (conv_result)
    );

    ////////////////////////////////////////////////////////////////////////
    // current source steering
    always_comb begin
        exc.burnout     = st_ff.exc[arc_pkg::BIT_BURNOUT];
        exc.aux_corr    = st_ff.exc[arc_pkg::BIT_AUX_CORR];
        exc.prim_corr   = st_ff.exc[arc_pkg::BIT_PRIM_CORR];
        // no exclusion: both sources may share one pin
        exc.src2_first  = st_ff.exc[arc_pkg::BIT_SRC2_EN]
                        & st_ff.exc[arc_pkg::BIT_SRC2_PIN];
        exc.src2_second = st_ff.exc[arc_pkg::BIT_SRC2_EN]
                        & ~st_ff.exc[arc_pkg::BIT_SRC2_PIN];
        exc.src1_second = st_ff.exc[arc_pkg::BIT_SRC1_EN]
                        & st_ff.exc[arc_pkg::BIT_SRC1_PIN];
        exc.src1_first  = st_ff.exc[arc_pkg::BIT_SRC1_EN]
                        & ~st_ff.exc[arc_pkg::BIT_SRC1_PIN];
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_decim_reset: assert property (
        @(posedge ref_clk) $rose(rst_n) |-> st_ff.decim == arc_pkg::DECIM_RESET)
        else $error("decimation factor reset value wrong");
    a_decim_lock: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_decim && conv_any |=> $stable(st_ff.decim))
        else $error("decimation factor written while converting");
    a_decim_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_decim && !conv_any |=> st_ff.decim == $past(sfr_req.wdata))
        else $error("decimation factor write lost");
    a_cal_factor: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        cal.busy |-> decimation_factor_eff == arc_pkg::DECIM_CAL)
        else $error("calibration not at maximum factor");
    a_cal_restore: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(cal.busy) |-> decimation_factor_eff == st_ff.decim)
        else $error("programmed factor not restored");
    a_exc_reserved: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_exc |=> st_ff.exc[7] == 1'b0 &&
                   st_ff.exc[6:0] == $past(sfr_req.wdata[6:0]))
        else $error("current control write wrong");
    a_src_route: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_exc && sfr_req.wdata[1] && sfr_req.wdata[3]
        |=> exc.src2_first && !exc.src2_second)
        else $error("source two not on first pin");
    a_src_shared: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_exc && sfr_req.wdata[3:0] == 4'hB
        |=> exc.src1_first && exc.src2_first &&
            !exc.src1_second && !exc.src2_second)
        else $error("both sources not shared on first pin");
    a_burnout: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_exc |=> exc.burnout == $past(sfr_req.wdata[6]))
        else $error("burnout enable wrong");
    a_factory_load: assert property (
        @(posedge ref_clk) $rose(rst_n) |=> aux_gain_coef == $past(factory_gain))
        else $error("factory gain not loaded");

endmodule // arc_ctrl
`default_nettype wire

// File: tb/test_adc_rate_cal_excitation_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_rate_cal_excitation_ctrl;

    ////////////////////////////////////////////////////////////////////////
    // bench signals and model state
    localparam int MD = 2;
    logic                      ref_clk = 1'b0;
    logic                      rstn = 1'b0;
    arc_pkg::arc_sfr_req_t     sfr_req = '0;
    logic [7:0]                sfr_rdata;
    logic [2:0]                converter_mode_field = 3'h0;
    logic                      primary_active = 1'b0;
    logic                      aux_active = 1'b0;
    logic                      conv_start = 1'b0;
    logic                      conv_continuous = 1'b0;
    arc_pkg::arc_cal_t         cal = '0;
    logic [15:0]               factory_gain = 16'h0000;
    logic [7:0]                decimation_factor_eff;
    logic [15:0]               aux_gain_coef;
    logic                      conv_busy;
    logic                      conv_result;
    arc_pkg::arc_exc_t         exc;
    int                        err_count = 0;
    int                        check_count = 0;
    int                        seed = 32'hA4F6;
    int                        gain_m;
    int                        n;
    logic [7:0]                lo;
    logic [7:0]                hi;
    logic [7:0]                v;

    always #4 ref_clk = ~ref_clk;

    arc_ctrl #(.MOD_DIV(MD), .DECIM_ADDR(arc_pkg::ADDR_DECIM)) arc_ctrl_inst (
        .ref_clk               (ref_clk),
        .rstn                  (rstn),
        .sfr_req               (sfr_req),
        .sfr_rdata             (sfr_rdata),
        .converter_mode_field  (converter_mode_field),
        .primary_active        (primary_active),
        .aux_active            (aux_active),
        .conv_start            (conv_start),
        .conv_continuous       (conv_continuous),
        .cal                   (cal),
        .factory_gain          (factory_gain),
        .decimation_factor_eff (decimation_factor_eff),
        .aux_gain_coef         (aux_gain_coef),
        .conv_busy             (conv_busy),
        .conv_result           (conv_result),
        .exc                   (exc)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        err_count++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask

    task automatic chk_reg(input string what, input logic [7:0] got,
                           input int exp);
        check_count++;
        if (got !== exp[7:0]) fail($sformatf("%s got %h exp %h", what, got,
                                             exp[7:0]));
    endtask

    task automatic chk_gain(input logic [15:0] got, input int exp);
        check_count++;
        if (got !== exp[15:0]) fail($sformatf("gain got %h exp %h", got,
                                              exp[15:0]));
    endtask

    task automatic chk_exc(input logic [7:0] b);
        arc_pkg::arc_exc_t e;
        e.burnout     = b[6];
        e.aux_corr    = b[5];
        e.prim_corr   = b[4];
        e.src1_first  = b[0] & ~b[2];
        e.src1_second = b[0] & b[2];
        e.src2_first  = b[1] & b[3];
        e.src2_second = b[1] & ~b[3];
        check_count++;
        if (exc !== e) fail($sformatf("exc got %b exp %b", exc, e));
    endtask

    task automatic chk_time(input string what, input int k, input int lo_b,
                            input int hi_b);
        check_count++;
        if (k < lo_b || k > hi_b) fail($sformatf("%s took %0d", what, k));
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req.addr  = a;
        sfr_req.wdata = d;
        sfr_req.wr    = 1'b1;
        tick();
        sfr_req.wr = 1'b0;
        tick();
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input int exp);
        sfr_req.addr = a;
        sfr_req.rd   = 1'b1;
        tick();
        sfr_req.rd = 1'b0;
        tick();
        chk_reg(what, sfr_rdata, exp);
    endtask

    task automatic wait_result(output int k);
        k = 0;
        do begin
            tick();
            k++;
        end while (conv_result !== 1'b1 && k < 20000);
        if (conv_result !== 1'b1) begin
            fail("no conversion result");
            summarize();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        factory_gain = 16'($random(seed));
        repeat (3) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (4) tick();
        gain_m = factory_gain;
        chk_gain(aux_gain_coef, gain_m);
        chk_reg("decim eff", decimation_factor_eff, 'h45);
        rd_chk("decim reset", arc_pkg::ADDR_DECIM, 'h45);
        rd_chk("exc reset", 8'hD5, 'h00);
        chk_exc(8'h00);
        $display("test reset done");

        for (int i = 0; i < 16; i++) begin
            v = (8'($random(seed)) & 8'hF0) | 8'(i);
            sfr_wr(8'hD5, v);
            chk_exc(v);
            rd_chk("exc read", 8'hD5, v & 8'h7F);
        end
        $display("test current control done");

        for (int m = 7; m >= 0; m--) begin
            converter_mode_field = 3'(m);
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            sfr_wr(8'hEC, lo);
            sfr_wr(8'hED, hi);
            if (m == 0) gain_m = {hi, lo};
            chk_gain(aux_gain_coef, gain_m);
            rd_chk("gain hi", 8'hED, gain_m >> 8);
            rd_chk("gain lo", 8'hEC, gain_m & 'hFF);
        end
        converter_mode_field = 3'h3;
        cal.gain = 16'($random(seed));
        cal.gain_done = 1'b1;
        tick();
        cal.gain_done = 1'b0;
        tick();
        gain_m = cal.gain;
        chk_gain(aux_gain_coef, gain_m);
        converter_mode_field = 3'h0;
        $display("test gain done");

        sfr_wr(arc_pkg::ADDR_DECIM, 8'h0D);
        rd_chk("decim idle", arc_pkg::ADDR_DECIM, 'h0D);
        primary_active = 1'b1;
        sfr_wr(arc_pkg::ADDR_DECIM, 8'h80);
        rd_chk("decim primary", arc_pkg::ADDR_DECIM, 'h0D);
        primary_active = 1'b0;
        aux_active = 1'b1;
        sfr_wr(arc_pkg::ADDR_DECIM, 8'h81);
        rd_chk("decim aux", arc_pkg::ADDR_DECIM, 'h0D);
        aux_active = 1'b0;
        sfr_wr(8'h00, 8'h5A);
        rd_chk("unmapped", 8'h00, 'h00);
        cal.busy = 1'b1;
        tick();
        chk_reg("cal eff", decimation_factor_eff, 'hFF);
        rd_chk("cal decim", arc_pkg::ADDR_DECIM, 'h0D);
        cal.busy = 1'b0;
        tick();
        chk_reg("after cal eff", decimation_factor_eff, 'h0D);
        $display("test decimation done");

        for (int j = 0; j < 2; j++) begin
            v = (j == 0) ? arc_pkg::DECIM_MIN : arc_pkg::DECIM_RESET;
            sfr_wr(arc_pkg::ADDR_DECIM, v);
            n = int'(arc_pkg::FILTER_MUL) * int'(v) * MD;
            conv_continuous = (j == 1);
            conv_start = 1'b1;
            tick();
            conv_start = 1'b0;
            wait_result(gain_m);
            chk_time("first result", gain_m, 2 * n - MD + 1, 2 * n);
            if (j == 1) begin
                wait_result(gain_m);
                chk_time("period", gain_m, n, n);
                sfr_wr(arc_pkg::ADDR_DECIM, 8'h20);
                rd_chk("decim busy", arc_pkg::ADDR_DECIM, 'h45);
                conv_continuous = 1'b0;
            end
            repeat (3) tick();
            chk_reg("busy", {7'h00, conv_busy}, 'h00);
        end
        $display("test conversion done");
        summarize();
    end

endmodule // test_adc_rate_cal_excitation_ctrl
`default_nettype wire
